// file: shared/dfm_pkg.sv
// Purpose: constants and types for the dsp firmware memory and core control block
// Assumes: apb slave on pclk, 32-bit data, byte addresses as printed
// Notes: memory depths are reduced stand-ins, kept at one bank size for every region
package dfm_pkg;
    // apb bus
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // memory geometry
    localparam int BANK_WORDS = 4;
    localparam int PM_BANKS = 5;
    localparam int XM_BANKS = 11;
    localparam int YM_BANKS = 6;
    localparam int PM_WORDS = PM_BANKS * BANK_WORDS;
    localparam int XM_WORDS = XM_BANKS * BANK_WORDS;
    localparam int YM_WORDS = YM_BANKS * BANK_WORDS;
    localparam int PM_W = 40;
    localparam int DM_W = 24;
    localparam int U32_HALF = 16;
    // register counts per window
    localparam int PM_REGS = PM_WORDS * 5 / 4;
    localparam int PM_GRP_REGS = 5;
    localparam int DM_GRP_REGS = 3;
    localparam int GRP_WORDS = 4;
    // memory windows (byte addresses)
    localparam logic [31:0] PM_BASE = 32'h0380_0000;
    localparam logic [31:0] XM_PACK_BASE = 32'h0200_0000;
    localparam logic [31:0] XM_U32_BASE = 32'h0240_0000;
    localparam logic [31:0] XM_U24_BASE = 32'h0280_0000;
    localparam logic [31:0] YM_PACK_BASE = 32'h02C0_0000;
    localparam logic [31:0] YM_U32_BASE = 32'h0300_0000;
    localparam logic [31:0] YM_U24_BASE = 32'h0340_0000;
    // bank enable registers
    localparam logic [31:0] XM_BANK_EN_FIRST = 32'h0001_7010;
    localparam logic [31:0] XM_BANK_EN_LAST = 32'h0001_7038;
    localparam logic [31:0] YM_BANK_EN_FIRST = 32'h0001_7040;
    localparam logic [31:0] YM_BANK_EN_LAST = 32'h0001_7054;
    localparam logic [31:0] PM_BANK_EN_FIRST = 32'h0001_705C;
    localparam logic [31:0] PM_BANK_EN_LAST = 32'h0001_706C;
    localparam int EVEN_BIT = 1;
    localparam int ODD_BIT = 0;
    // control registers
    localparam logic [31:0] CLK_REQ_ADDR = 32'h02B8_0000;
    localparam logic [31:0] CLK_ACT_ADDR = 32'h02B8_0008;
    localparam logic [31:0] SOFT_RST_ADDR = 32'h02B8_0010;
    localparam logic [31:0] RESYNC_ADDR = 32'h02B8_0050;
    localparam logic [31:0] CORE_CTRL_ADDR = 32'h02BC_1000;
    localparam logic [31:0] RESYNC_MSK_ADDR = 32'h02BC_5A00;
    localparam int CORE_EN_BIT = 0;
    localparam int CORE_RST_BIT = 9;
    localparam int PULSE_BIT = 0;
    localparam int MASTERS = 8;
    // clock select, lsb = 1/64 MHz; 150 MHz ceiling
    localparam int FREQ_W = 16;
    localparam logic [15:0] CLK_MAX_CODE = 16'(150 * 64);
    localparam logic [15:0] CLK_REQ_RST = 16'h0000;
    localparam logic [PM_W-1:0] CORE_START_ADDR = 40'h00_0000_0000;
    // core side control bundle
    typedef struct packed {
        logic run_enable;
        logic hold_reset;
        logic core_reset_pulse;
        logic subsystem_soft_reset;
        logic [PM_W-1:0] start_addr;
    } dfm_core_ctrl_t;
    // clock side bundle
    typedef struct packed {
        logic gate_en;
        logic [FREQ_W-1:0] divider;
        logic [FREQ_W-1:0] actual;
        logic clk_low_event;
    } dfm_clk_ctrl_t;
endpackage

// file: verilog/dfm_core.sv
// Purpose: host access to dsp firmware memories, bank enables, clock select and core control
// Assumes: apb slave with zero wait states, read data latched in the setup cycle
// Notes: memory arrays carry no reset so their contents are not cleared by any reset
`timescale 1ns/10ps
module dfm_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source clock rate and arbiter activity
    input wire logic [15:0] processor_source_clock,
    input wire logic [7:0] arbiter_master_en,
    // core, clock and arbiter controls
    output dfm_pkg::dfm_core_ctrl_t core_ctrl,
    output dfm_pkg::dfm_clk_ctrl_t clk_ctrl,
    output logic [7:0] arbiter_resync
);
    typedef struct packed {
        logic [dfm_pkg::XM_BANKS-1:0][1:0] xmem_bank_en;
        logic [dfm_pkg::YM_BANKS-1:0][1:0] ymem_bank_en;
        logic [dfm_pkg::PM_BANKS-1:0][1:0] pmem_bank_en;
        logic [dfm_pkg::FREQ_W-1:0] core_clk_request;
        logic [dfm_pkg::FREQ_W-1:0] clk_div;
        logic [dfm_pkg::FREQ_W-1:0] clk_actual;
        logic clk_low;
        logic clk_low_event;
        logic core_run_enable;
        logic core_reset_pulse;
        logic subsystem_soft_reset;
        logic [dfm_pkg::MASTERS-1:0] arbiter_resync_mask;
        logic [dfm_pkg::MASTERS-1:0] arbiter_resync;
        logic [31:0] rdata;
        logic rerr;
    } dfm_state_t;

    dfm_state_t st_q;
    dfm_state_t st_d;

    // storage, no reset on purpose
    logic [dfm_pkg::PM_W-1:0] pm_mem [dfm_pkg::PM_WORDS];
    logic [dfm_pkg::DM_W-1:0] dm_mem [2][dfm_pkg::XM_WORDS];
    logic pm_we [dfm_pkg::PM_WORDS];
    logic [dfm_pkg::PM_W-1:0] pm_wd [dfm_pkg::PM_WORDS];
    logic dm_we [2][dfm_pkg::XM_WORDS];
    logic [dfm_pkg::DM_W-1:0] dm_wd [2][dfm_pkg::XM_WORDS];

    // register-aligned window hit
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] base, input int nregs);
        logic [31:0] off;
        off = a - base;
        return (a >= base) && (off[1:0] == 2'h0) && (off[31:2] < 30'(nregs));
    endfunction

    // register index within a window
    function automatic int win_idx(input logic [31:0] a, input logic [31:0] base);
        logic [31:0] off;
        off = a - base;
        return int'(off[31:2]);
    endfunction

    // clock divider: largest division still at or above the request, capped by the dsp maximum
    function automatic logic [15:0] calc_div(input logic [15:0] src, input logic [15:0] req);
        logic [15:0] d;
        logic [15:0] dmin;
        d = (req == 16'h0000) ? 16'h0001 : src / req;
        dmin = 16'((32'(src) + 32'(dfm_pkg::CLK_MAX_CODE) - 32'h1) / 32'(dfm_pkg::CLK_MAX_CODE));
        if (d < dmin) begin
            d = dmin;
        end
        if (d == 16'h0000) begin
            d = 16'h0001;
        end
        return d;
    endfunction

    logic acc_wr;
    logic setup;
    logic [31:0] rd;
    logic err;
    logic [dfm_pkg::FREQ_W-1:0] div_c;
    logic [dfm_pkg::FREQ_W-1:0] act_c;

    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite;

    // memory decode: reads for the setup-cycle latch, writes in the access cycle
    always_comb begin
        int idx;
        int g;
        int k;
        int w;
        logic [dfm_pkg::PM_W*dfm_pkg::GRP_WORDS-1:0] pgrp;
        logic [dfm_pkg::DM_W*dfm_pkg::GRP_WORDS-1:0] dgrp;
        logic [31:0] base_p;
        logic [31:0] base_32;
        logic [31:0] base_24;
        int nw;
        idx = 0;
        g = 0;
        k = 0;
        w = 0;
        pgrp = '0;
        dgrp = '0;
        base_p = '0;
        base_32 = '0;
        base_24 = '0;
        nw = 0;
        rd = 32'h0000_0000;
        err = 1'b1;
        for (int i = 0; i < dfm_pkg::PM_WORDS; i++) begin
            pm_we[i] = 1'b0;
            pm_wd[i] = pm_mem[i];
        end
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < dfm_pkg::XM_WORDS; i++) begin
                dm_we[m][i] = 1'b0;
                dm_wd[m][i] = dm_mem[m][i];
            end
        end
        // program memory, four words in five registers
        if (in_win(paddr, dfm_pkg::PM_BASE, dfm_pkg::PM_REGS)) begin
            idx = win_idx(paddr, dfm_pkg::PM_BASE);
            g = idx / dfm_pkg::PM_GRP_REGS;
            k = idx % dfm_pkg::PM_GRP_REGS;
            for (int j = 0; j < dfm_pkg::GRP_WORDS; j++) begin
                w = g * dfm_pkg::GRP_WORDS + j;
                if (st_q.pmem_bank_en[w / dfm_pkg::BANK_WORDS][(w % 2 == 1) ? dfm_pkg::ODD_BIT : dfm_pkg::EVEN_BIT]) begin
                    pgrp[dfm_pkg::PM_W*j +: dfm_pkg::PM_W] = pm_mem[w];
                end
            end
            rd = pgrp[32*k +: 32];
            err = 1'b0;
            pgrp[32*k +: 32] = pwdata;
            for (int j = 0; j < dfm_pkg::GRP_WORDS; j++) begin
                w = g * dfm_pkg::GRP_WORDS + j;
                if (acc_wr && st_q.pmem_bank_en[w / dfm_pkg::BANK_WORDS][(w % 2 == 1) ? dfm_pkg::ODD_BIT : dfm_pkg::EVEN_BIT]) begin
                    pm_we[w] = 1'b1;
                    pm_wd[w] = pgrp[dfm_pkg::PM_W*j +: dfm_pkg::PM_W];
                end
            end
        end
        // data memories, three windows onto one array each
        for (int m = 0; m < 2; m++) begin
            base_p = (m == 0) ? dfm_pkg::XM_PACK_BASE : dfm_pkg::YM_PACK_BASE;
            base_32 = (m == 0) ? dfm_pkg::XM_U32_BASE : dfm_pkg::YM_U32_BASE;
            base_24 = (m == 0) ? dfm_pkg::XM_U24_BASE : dfm_pkg::YM_U24_BASE;
            nw = (m == 0) ? dfm_pkg::XM_WORDS : dfm_pkg::YM_WORDS;
            if (in_win(paddr, base_p, nw * dfm_pkg::DM_GRP_REGS / dfm_pkg::GRP_WORDS)) begin
                idx = win_idx(paddr, base_p);
                g = idx / dfm_pkg::DM_GRP_REGS;
                k = idx % dfm_pkg::DM_GRP_REGS;
                dgrp = '0;
                for (int j = 0; j < dfm_pkg::GRP_WORDS; j++) begin
                    w = g * dfm_pkg::GRP_WORDS + j;
                    if (bank_ok(m, w)) begin
                        dgrp[dfm_pkg::DM_W*j +: dfm_pkg::DM_W] = dm_mem[m][w];
                    end
                end
                rd = dgrp[32*k +: 32];
                err = 1'b0;
                dgrp[32*k +: 32] = pwdata;
                for (int j = 0; j < dfm_pkg::GRP_WORDS; j++) begin
                    w = g * dfm_pkg::GRP_WORDS + j;
                    if (acc_wr && bank_ok(m, w)) begin
                        dm_we[m][w] = 1'b1;
                        dm_wd[m][w] = dgrp[dfm_pkg::DM_W*j +: dfm_pkg::DM_W];
                    end
                end
            end
            if (in_win(paddr, base_24, nw)) begin
                idx = win_idx(paddr, base_24);
                rd = bank_ok(m, idx) ? {8'h00, dm_mem[m][idx]} : 32'h0000_0000;
                err = 1'b0;
                if (acc_wr && bank_ok(m, idx)) begin
                    dm_we[m][idx] = 1'b1;
                    dm_wd[m][idx] = pwdata[dfm_pkg::DM_W-1:0];
                end
            end
            if (in_win(paddr, base_32, nw / 2)) begin
                idx = win_idx(paddr, base_32);
                for (int h = 0; h < 2; h++) begin
                    w = 2 * idx + h;
                    if (bank_ok(m, w)) begin
                        rd[dfm_pkg::U32_HALF*h +: dfm_pkg::U32_HALF] = dm_mem[m][w][dfm_pkg::U32_HALF-1:0];
                    end
                    if (acc_wr && bank_ok(m, w)) begin
                        dm_we[m][w] = 1'b1;
                        dm_wd[m][w] = {8'h00, pwdata[dfm_pkg::U32_HALF*h +: dfm_pkg::U32_HALF]};
                    end
                end
                err = 1'b0;
            end
        end
    end

    // word enabled by its bank's even or odd enable
    function automatic logic bank_ok(input int m, input int w);
        int b;
        int p;
        b = w / dfm_pkg::BANK_WORDS;
        p = (w % 2 == 1) ? dfm_pkg::ODD_BIT : dfm_pkg::EVEN_BIT;
        if (m == 0) begin
            return st_q.xmem_bank_en[b][p];
        end
        return st_q.ymem_bank_en[b][p];
    endfunction

    // divider and achieved frequency from source and request
    assign div_c = calc_div(processor_source_clock, st_q.core_clk_request);
    assign act_c = processor_source_clock / div_c;

    // register file, pulses and clock bookkeeping
    always_comb begin
        int b;
        logic [31:0] rsel;
        logic rhit;
        b = 0;
        st_d = st_q;
        rsel = 32'h0000_0000;
        rhit = 1'b0;
        st_d.core_reset_pulse = 1'b0;
        st_d.subsystem_soft_reset = 1'b0;
        st_d.arbiter_resync = '0;
        st_d.clk_div = div_c;
        st_d.clk_actual = act_c;
        st_d.clk_low = st_q.core_run_enable && (act_c < st_q.core_clk_request);
        st_d.clk_low_event = st_d.clk_low && !st_q.clk_low;
        // bank enable registers
        if (in_win(paddr, dfm_pkg::XM_BANK_EN_FIRST, dfm_pkg::XM_BANKS)) begin
            b = win_idx(paddr, dfm_pkg::XM_BANK_EN_FIRST);
            rsel = {30'h0, st_q.xmem_bank_en[b]};
            rhit = 1'b1;
            if (acc_wr) begin
                st_d.xmem_bank_en[b] = pwdata[1:0];
            end
        end
        if (in_win(paddr, dfm_pkg::YM_BANK_EN_FIRST, dfm_pkg::YM_BANKS)) begin
            b = win_idx(paddr, dfm_pkg::YM_BANK_EN_FIRST);
            rsel = {30'h0, st_q.ymem_bank_en[b]};
            rhit = 1'b1;
            if (acc_wr) begin
                st_d.ymem_bank_en[b] = pwdata[1:0];
            end
        end
        if (in_win(paddr, dfm_pkg::PM_BANK_EN_FIRST, dfm_pkg::PM_BANKS)) begin
            b = win_idx(paddr, dfm_pkg::PM_BANK_EN_FIRST);
            rsel = {30'h0, st_q.pmem_bank_en[b]};
            rhit = 1'b1;
            if (acc_wr) begin
                st_d.pmem_bank_en[b] = pwdata[1:0];
            end
        end
        // control registers
        case (paddr)
            dfm_pkg::CLK_REQ_ADDR: begin
                rsel = {16'h0000, st_q.core_clk_request};
                rhit = 1'b1;
                if (acc_wr) begin
                    st_d.core_clk_request = pwdata[dfm_pkg::FREQ_W-1:0];
                end
            end
            dfm_pkg::CLK_ACT_ADDR: begin
                rsel = {16'h0000, st_q.core_run_enable ? st_q.clk_actual : 16'h0000};
                rhit = 1'b1;
            end
            dfm_pkg::SOFT_RST_ADDR: begin
                rhit = 1'b1;
                if (acc_wr) begin
                    st_d.subsystem_soft_reset = pwdata[dfm_pkg::PULSE_BIT];
                end
            end
            dfm_pkg::RESYNC_ADDR: begin
                rhit = 1'b1;
                if (acc_wr && pwdata[dfm_pkg::PULSE_BIT]) begin
                    st_d.arbiter_resync = st_q.arbiter_resync_mask;
                end
            end
            dfm_pkg::CORE_CTRL_ADDR: begin
                rsel = 32'(st_q.core_run_enable) << dfm_pkg::CORE_EN_BIT;
                rhit = 1'b1;
                if (acc_wr) begin
                    st_d.core_run_enable = pwdata[dfm_pkg::CORE_EN_BIT];
                    st_d.core_reset_pulse = pwdata[dfm_pkg::CORE_RST_BIT];
                end
            end
            dfm_pkg::RESYNC_MSK_ADDR: begin
                rsel = {24'h00_0000, st_q.arbiter_resync_mask};
                rhit = 1'b1;
                if (acc_wr) begin
                    st_d.arbiter_resync_mask = pwdata[dfm_pkg::MASTERS-1:0];
                end
            end
            default: begin
            end
        endcase
        // subsystem soft reset returns clock select to default; bank enables kept
        if (st_q.subsystem_soft_reset) begin
            st_d.core_clk_request = dfm_pkg::CLK_REQ_RST;
        end
        // read data latched in the setup cycle
        if (setup) begin
            st_d.rdata = rhit ? rsel : rd;
            st_d.rerr = !rhit && err;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // memory arrays, apb clock only, never cleared
    always_ff @(posedge pclk) begin
        for (int i = 0; i < dfm_pkg::PM_WORDS; i++) begin
            if (pm_we[i]) begin
                pm_mem[i] <= pm_wd[i];
            end
        end
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < dfm_pkg::XM_WORDS; i++) begin
                if (dm_we[m][i]) begin
                    dm_mem[m][i] <= dm_wd[m][i];
                end
            end
        end
    end

    // apb answer, zero wait states
    assign pready = 1'b1;
    assign prdata = st_q.rdata;
    assign pslverr = psel & penable & st_q.rerr;

    // core control outputs
    assign core_ctrl.run_enable = st_q.core_run_enable;
    assign core_ctrl.hold_reset = !st_q.core_run_enable | st_q.core_reset_pulse | st_q.subsystem_soft_reset;
    assign core_ctrl.core_reset_pulse = st_q.core_reset_pulse | st_q.subsystem_soft_reset;
    assign core_ctrl.subsystem_soft_reset = st_q.subsystem_soft_reset;
    assign core_ctrl.start_addr = dfm_pkg::CORE_START_ADDR;

    // clock and arbiter resync outputs
    assign clk_ctrl.gate_en = st_q.core_run_enable | (|arbiter_master_en);
    assign clk_ctrl.divider = st_q.clk_div;
    assign clk_ctrl.actual = st_q.clk_actual;
    assign clk_ctrl.clk_low_event = st_q.clk_low_event;
    assign arbiter_resync = st_q.arbiter_resync | (st_q.subsystem_soft_reset ? 8'hFF : 8'h00);
endmodule

// file: tb/dfm_core_monitor.sv
// Purpose: concurrent checks on the dsp firmware memory and core control ports
// Assumes: apb writes land in the access cycle, control pulses follow one cycle later
// Notes: a local copy of the resync mask lets the checker predict resync pulses
`timescale 1ns/10ps
module dfm_core_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // activity inputs and control outputs
    input wire logic [7:0] arbiter_master_en,
    input wire dfm_pkg::dfm_core_ctrl_t core_ctrl,
    input wire dfm_pkg::dfm_clk_ctrl_t clk_ctrl,
    input wire logic [7:0] arbiter_resync
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] mask_q;
    // copy of the resync mask as last written by the host
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 8'h00;
        end else if (psel && penable && pwrite && pready && paddr == dfm_pkg::RESYNC_MSK_ADDR) begin
            mask_q <= pwdata[7:0];
        end
    end
    // completed host write to one address
    sequence s_wr(logic [31:0] a);
        psel && penable && pwrite && pready && paddr == a;
    endsequence
    gate_follow_a: assert property (clk_ctrl.gate_en == (core_ctrl.run_enable || (|arbiter_master_en)))
        else $error("clock gate does not follow core and arbiter activity");
    core_hold_a: assert property (!core_ctrl.run_enable |-> core_ctrl.hold_reset)
        else $error("core not held in reset while disabled");
    core_run_a: assert property (core_ctrl.run_enable && !core_ctrl.core_reset_pulse |-> !core_ctrl.hold_reset)
        else $error("core held in reset while enabled");
    core_reset_a: assert property (s_wr(dfm_pkg::CORE_CTRL_ADDR) ##0 pwdata[9] |=>
        core_ctrl.core_reset_pulse && core_ctrl.hold_reset ##1 !core_ctrl.core_reset_pulse)
        else $error("core reset write gave no single pulse");
    soft_reset_a: assert property (s_wr(dfm_pkg::SOFT_RST_ADDR) ##0 pwdata[0] |=>
        core_ctrl.subsystem_soft_reset && core_ctrl.core_reset_pulse && arbiter_resync == 8'hFF
        ##1 !core_ctrl.subsystem_soft_reset)
        else $error("soft reset write gave wrong pulses");
    resync_mask_a: assert property (s_wr(dfm_pkg::RESYNC_ADDR) ##0 pwdata[0] |=> arbiter_resync == mask_q)
        else $error("resync pulse does not match mask");
    start_addr_a: assert property (core_ctrl.start_addr == dfm_pkg::CORE_START_ADDR)
        else $error("restart address is not program base");
    clk_cap_a: assert property (clk_ctrl.actual <= dfm_pkg::CLK_MAX_CODE)
        else $error("actual clock above core ceiling");
    low_pulse_a: assert property (clk_ctrl.clk_low_event |=> !clk_ctrl.clk_low_event)
        else $error("low clock event longer than one cycle");
endmodule
bind dfm_core dfm_core_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .arbiter_master_en(arbiter_master_en),
    .core_ctrl(core_ctrl), .clk_ctrl(clk_ctrl), .arbiter_resync(arbiter_resync));

// file: tb/dfm_host_model.sv
// Purpose: host processor model issuing apb transfers to the register map
// Assumes: full word transfers only
// Notes: signals change just after a rising edge and hold until pready is sampled high
`timescale 1ns/10ps
module dfm_host_model (
    // bus clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus from time zero; only the bus clock is offered
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // no watchdog of its own, so no slow clock is needed
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: tb/dsp_fw_memory_core_control_tb.sv
// Purpose: self-checking bench for the firmware memory and core control block
// Assumes: source clock code 0x1900 at start, run enable off until clocks are set
// Notes: table rows are written or read in order; control pulses checked by hand
`timescale 1ns/10ps
module dsp_fw_memory_core_control_tb;
    typedef struct packed {
        logic w;
        logic [31:0] a;
        logic [31:0] d;
    } dfm_row_t;
    localparam logic [31:0] XB = dfm_pkg::XM_BANK_EN_FIRST;
    localparam logic [31:0] XU = dfm_pkg::XM_U24_BASE;
    localparam logic [31:0] XP = dfm_pkg::XM_PACK_BASE;
    localparam logic [31:0] YU = dfm_pkg::YM_U24_BASE;
    localparam logic [31:0] Y3 = dfm_pkg::YM_U32_BASE;
    localparam logic [31:0] PB = dfm_pkg::PM_BASE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e, seen;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [15:0] src_rate = 16'h1900;
    logic [7:0] master_en = 8'h00;
    logic [7:0] resync;
    dfm_pkg::dfm_core_ctrl_t core_ctrl;
    dfm_pkg::dfm_clk_ctrl_t clk_ctrl;
    int n_fail = 0;
    int check_count = 0;
    // write rows store d, read rows expect d
    dfm_row_t rows [$] = '{'{1'b0, XB, 32'h0}, '{1'b0, dfm_pkg::PM_BANK_EN_LAST, 32'h0},
        '{1'b1, XB, 32'h3}, '{1'b1, dfm_pkg::YM_BANK_EN_FIRST, 32'h3}, '{1'b1, dfm_pkg::PM_BANK_EN_FIRST, 32'h3},
        '{1'b1, XB + 32'h4, 32'h1}, '{1'b0, XB + 32'h4, 32'h1},
        '{1'b1, XU, 32'hFF11_1111}, '{1'b1, XU + 32'h4, 32'h0022_2222}, '{1'b1, XU + 32'h8, 32'h0033_3333},
        '{1'b1, XU + 32'hC, 32'h0044_4444}, '{1'b0, XU, 32'h0011_1111},
        '{1'b0, XP, 32'h2211_1111}, '{1'b0, XP + 32'h4, 32'h3333_2222}, '{1'b0, XP + 32'h8, 32'h4444_4433},
        '{1'b1, Y3, 32'hDEAD_BEEF}, '{1'b0, YU, 32'h0000_BEEF}, '{1'b0, YU + 32'h4, 32'h0000_DEAD},
        '{1'b0, Y3, 32'hDEAD_BEEF}, '{1'b1, XU + 32'h10, 32'h0055_5555}, '{1'b0, XU + 32'h10, 32'h0},
        '{1'b1, XU + 32'h14, 32'h0066_6666}, '{1'b0, XU + 32'h14, 32'h0066_6666},
        '{1'b1, PB, 32'h89AB_CDEF}, '{1'b1, PB + 32'h4, 32'h0123_4567}, '{1'b1, PB + 32'h10, 32'hCAFE_F00D},
        '{1'b0, PB, 32'h89AB_CDEF}, '{1'b0, PB + 32'h4, 32'h0123_4567}, '{1'b0, PB + 32'h10, 32'hCAFE_F00D},
        '{1'b0, 32'h0000_0100, 32'h0}};
    // design, host model and bus clock
    always #20 pclk = ~pclk;
    dfm_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .processor_source_clock(src_rate), .arbiter_master_en(master_en), .core_ctrl(core_ctrl),
        .clk_ctrl(clk_ctrl), .arbiter_resync(resync));
    dfm_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one bus transfer; read data lands in q, error in e
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        i_host.xfer(w, a, d, q, e);
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("hold after reset", 32'h1, {31'h0, core_ctrl.hold_reset});
        chk("start address", 32'h0, core_ctrl.start_addr[31:0]);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("row read", rows[i].d, q);
            chk("row error", {31'h0, rows[i].a == 32'h0000_0100}, {31'h0, e});
        end
        acc(1'b1, dfm_pkg::CLK_REQ_ADDR, 32'h0C80);
        acc(1'b0, dfm_pkg::CLK_ACT_ADDR, 32'h0);
        chk("status while off", 32'h0, q);
        acc(1'b1, dfm_pkg::CORE_CTRL_ADDR, 32'h1);
        @(negedge pclk);
        chk("gate with core", 32'h1, {31'h0, clk_ctrl.gate_en});
        acc(1'b0, dfm_pkg::CLK_ACT_ADDR, 32'h0);
        chk("status", 32'h0C80, q);
        acc(1'b1, dfm_pkg::CLK_REQ_ADDR, 32'h0780);
        acc(1'b0, dfm_pkg::CLK_ACT_ADDR, 32'h0);
        chk("divided clock", 32'h0855, q);
        src_rate <= 16'h3200;
        acc(1'b1, dfm_pkg::CLK_REQ_ADDR, 32'h3200);
        seen = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            seen = seen | (clk_ctrl.clk_low_event === 1'b1);
        end
        chk("low clock event", 32'h1, {31'h0, seen});
        acc(1'b0, dfm_pkg::CLK_ACT_ADDR, 32'h0);
        chk("capped clock", 32'h1900, q);
        chk("divider", 32'h2, {16'h0, clk_ctrl.divider});
        acc(1'b1, dfm_pkg::CORE_CTRL_ADDR, 32'h201);
        @(negedge pclk);
        chk("core reset pulse", 32'h1, {31'h0, core_ctrl.core_reset_pulse});
        @(negedge pclk);
        chk("core reset ends", 32'h0, {31'h0, core_ctrl.core_reset_pulse});
        acc(1'b0, dfm_pkg::CORE_CTRL_ADDR, 32'h0);
        chk("core control", 32'h1, q);
        acc(1'b1, dfm_pkg::RESYNC_MSK_ADDR, 32'hA5);
        acc(1'b0, dfm_pkg::RESYNC_MSK_ADDR, 32'h0);
        chk("mask", 32'hA5, q);
        acc(1'b1, dfm_pkg::RESYNC_ADDR, 32'h1);
        @(negedge pclk);
        chk("resync", 32'hA5, {24'h0, resync});
        acc(1'b1, dfm_pkg::CORE_CTRL_ADDR, 32'h0);
        acc(1'b1, dfm_pkg::SOFT_RST_ADDR, 32'h1);
        @(negedge pclk);
        chk("soft resync", 32'hFF, {24'h0, resync});
        acc(1'b0, dfm_pkg::CLK_REQ_ADDR, 32'h0);
        chk("request cleared", 32'h0, q);
        acc(1'b0, XB, 32'h0);
        chk("enable kept", 32'h3, q);
        acc(1'b0, XU + 32'h14, 32'h0);
        chk("content kept", 32'h0066_6666, q);
        master_en <= 8'h04;
        @(negedge pclk);
        chk("gate with arbiter", 32'h1, {31'h0, clk_ctrl.gate_en});
        @(posedge pclk);
        master_en <= 8'h00;
        @(negedge pclk);
        chk("gate idle", 32'h0, {31'h0, clk_ctrl.gate_en});
        stop_test();
    end
endmodule
